// *** shared/ldo_pkg.sv ***
// Purpose: constants and types for the regulator control register bank
// Assumes: register offsets are byte addresses on the serial register port
// Notes: reset values are plain defaults

package ldo_pkg;

  // ==========================================================
  // sizes
  localparam int LDO_RAILS = 8;
  localparam int LDO_WIDE_IDX = 6;

  // ==========================================================
  // register offsets, index 0 is regulator 1
  localparam logic [7:0] LDO_WIDE_CODE_OFS = 8'h07;
  localparam logic [7:0] LDO_CTL_OFS [LDO_RAILS] = '{8'h0F, 8'h13, 8'h0C, 8'h10, 8'h0D, 8'h11, 8'h0E, 8'h12};
  localparam logic [7:0] LDO5_CTL_OFS = 8'h0D;
  localparam logic [7:0] LDO6_CTL_OFS = 8'h11;
  localparam logic [7:0] LDO7_CTL_OFS = 8'h0E;

  // ==========================================================
  // field positions
  localparam int LDO_DIS_BIT = 7;
  localparam int LDO_PG_BIT = 6;
  localparam int LDO_EN_BIT = 5;
  localparam int LDO_CODE_MSB = 4;
  localparam int LDO_RANGE_BIT = 6;
  localparam int LDO_WCODE_MSB = 5;
  localparam logic [1:0] LDO_TOP_BAND = 2'h3;
  localparam logic [3:0] LDO_TOP_LAST_STEP = 4'h1;

  // ==========================================================
  // reset values
  localparam logic [4:0] LDO_CODE_RST = 5'h00;
  localparam logic LDO_EN_RST = 1'b0;
  localparam logic LDO_DIS_RST = 1'b0;
  localparam logic [5:0] LDO_WCODE_RST = 6'h00;
  localparam logic LDO_RANGE_RST = 1'b0;
  localparam logic [7:0] LDO_UNMAPPED_RD = 8'h00;

  // ==========================================================
  // standard code table in millivolts: band base and step size
  localparam logic [11:0] LDO_BAND_BASE_MV [4] = '{12'h578, 12'h866, 12'h9F6, 12'hBB8};
  localparam logic [11:0] LDO_BAND_STEP_MV [4] = '{12'h064, 12'h032, 12'h032, 12'h064};

  typedef struct packed {
    logic discharge;
    logic enable;
    logic [4:0] code;
  } ldo_ctl_t;

  typedef logic [4:0] ldo_code_t;
  typedef logic [11:0] ldo_mv_t;

endpackage

// *** src/ldo_ctl_regs.sv ***
// Purpose: control register bank for the eight linear regulators
// Assumes: serial front end gives one-cycle read and write strobes
// Notes: pins and power-good comparator outputs are synchronous
`timescale 1ns/1ps

module ldo_ctl_regs
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic startup_done,
  input wire logic oscillator_rail_pin,
  input wire logic rx_rail_pin,
  input wire logic tx_rail_pin,
  input wire logic power_keep_pin,
  input wire logic [ldo_pkg::LDO_RAILS-1:0] pg_comp,
  output logic [ldo_pkg::LDO_RAILS-1:0] rail_on,
  output logic [ldo_pkg::LDO_RAILS-1:0] rail_discharge,
  output ldo_pkg::ldo_code_t rail_code [ldo_pkg::LDO_RAILS],
  output ldo_pkg::ldo_mv_t rail_target_mv [ldo_pkg::LDO_RAILS],
  output logic [5:0] wide_rail_voltage_code,
  output logic wide_rail_range_select
);
  import ldo_pkg::*;

  // ==========================================================
  // register state
  ldo_ctl_t ctl_r [LDO_RAILS];
  logic [LDO_RAILS-1:0] pg_r;
  logic [5:0] wcode_r;
  logic range_r;
  logic [LDO_RAILS-1:0] pin_req;
  logic wcode_ok;

  // pin to regulator assignment
  always_comb begin
    pin_req = {power_keep_pin, power_keep_pin, tx_rail_pin, rx_rail_pin, oscillator_rail_pin,
               power_keep_pin, power_keep_pin, power_keep_pin};
  end

  // top band of range 1 only has two steps
  always_comb begin
    wcode_ok = !(reg_wdata[LDO_RANGE_BIT] && reg_wdata[LDO_WCODE_MSB -: 2] == LDO_TOP_BAND &&
                 reg_wdata[3:0] > LDO_TOP_LAST_STEP);
  end

  // comparator already carries threshold and hysteresis
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pg_r <= '0;
    end else begin
      pg_r <= pg_comp;
    end
  end

  // ==========================================================
  // per-rail control registers and outputs
  genvar g;
  generate
    for (g = 0; g < LDO_RAILS; g++) begin : g_rail
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          ctl_r[g] <= '{discharge: LDO_DIS_RST, enable: LDO_EN_RST, code: LDO_CODE_RST};
        end else if (reg_wr && reg_addr == LDO_CTL_OFS[g]) begin
          ctl_r[g].discharge <= reg_wdata[LDO_DIS_BIT];
          ctl_r[g].enable <= reg_wdata[LDO_EN_BIT];
          if (g != LDO_WIDE_IDX) begin
            ctl_r[g].code <= reg_wdata[LDO_CODE_MSB:0];
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          rail_on[g] <= 1'b0;
          rail_discharge[g] <= 1'b0;
          rail_code[g] <= LDO_CODE_RST;
          rail_target_mv[g] <= '0;
        end else begin
          rail_on[g] <= ctl_r[g].enable || (startup_done && pin_req[g]);
          rail_discharge[g] <= ctl_r[g].discharge && !(ctl_r[g].enable || (startup_done && pin_req[g]));
          rail_code[g] <= ctl_r[g].code;
          if (g == LDO_WIDE_IDX) begin
            rail_target_mv[g] <= '0;
          end else begin
            rail_target_mv[g] <= LDO_BAND_BASE_MV[ctl_r[g].code[4:3]] +
                                 12'(LDO_BAND_STEP_MV[ctl_r[g].code[4:3]] * ctl_r[g].code[2:0]);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // wide-range rail code register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wcode_r <= LDO_WCODE_RST;
      range_r <= LDO_RANGE_RST;
    end else if (reg_wr && reg_addr == LDO_WIDE_CODE_OFS && wcode_ok) begin
      wcode_r <= reg_wdata[LDO_WCODE_MSB:0];
      range_r <= reg_wdata[LDO_RANGE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wide_rail_voltage_code <= LDO_WCODE_RST;
      wide_rail_range_select <= LDO_RANGE_RST;
    end else begin
      wide_rail_voltage_code <= wcode_r;
      wide_rail_range_select <= range_r;
    end
  end

  // ==========================================================
  // read path
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = LDO_UNMAPPED_RD;
    if (reg_addr == LDO_WIDE_CODE_OFS) begin
      rd_nxt = {1'b0, range_r, wcode_r};
    end
    for (int i = 0; i < LDO_RAILS; i++) begin
      if (reg_addr == LDO_CTL_OFS[i]) begin
        rd_nxt = {ctl_r[i].discharge, pg_r[i], ctl_r[i].enable, ctl_r[i].code};
        if (i == LDO_WIDE_IDX) begin
          rd_nxt[LDO_CODE_MSB:0] = 5'h00;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_nxt;
      end
    end
  end

  // ==========================================================
  // checks
  pg_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == LDO5_CTL_OFS |=> reg_rdata[LDO_PG_BIT] == $past(pg_r[4]))
    else $error("power-good read mismatch");

  dis_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    rail_discharge[5] |-> !rail_on[5])
    else $error("discharge while rail on");

  wide_ro_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == LDO7_CTL_OFS |=> reg_rdata[4:0] == 5'h00)
    else $error("wide rail low bits not zero");

  rail6_en_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == LDO6_CTL_OFS && reg_wdata[LDO_EN_BIT] |=> ##1 rail_on[5])
    else $error("rail6 enable not applied");

  code_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == LDO6_CTL_OFS |-> ##2 rail_code[5] == $past(reg_wdata[4:0], 2))
    else $error("rail6 code not applied");

  band_mv_a: assert property (@(posedge sys_clk) disable iff (rst)
    rail_code[4] == 5'h18 && $stable(rail_code[4]) |-> rail_target_mv[4] == 12'hBB8)
    else $error("band decode wrong");

  wide_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == LDO_WIDE_CODE_OFS && reg_wdata == 8'h72 |=> $stable(wcode_r) && $stable(range_r))
    else $error("unavailable code accepted");

  wide_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == LDO_WIDE_CODE_OFS && wcode_ok |=> ##1
    wide_rail_range_select == $past(reg_wdata[LDO_RANGE_BIT], 2) &&
    wide_rail_voltage_code == $past(reg_wdata[5:0], 2))
    else $error("wide code not applied");

  pin_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    startup_done && tx_rail_pin |=> rail_on[5])
    else $error("pin did not enable rail6");

  pg_track_a: assert property (@(posedge sys_clk) disable iff (rst)
    pg_comp[5] |=> pg_r[5])
    else $error("power-good not tracking");

  pg_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    !pg_comp[5] |=> !pg_r[5])
    else $error("power-good not cleared");

  dis_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == LDO6_CTL_OFS |=> reg_rdata[LDO_DIS_BIT] == $past(ctl_r[5].discharge))
    else $error("discharge read mismatch");

  pin_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !startup_done && !ctl_r[0].enable |=> !rail_on[0])
    else $error("pin acted before startup");

  keep_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    startup_done && power_keep_pin |=> rail_on[0] && rail_on[1] && rail_on[2] && rail_on[6] && rail_on[7])
    else $error("keep pin did not enable rails");

  en_or_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctl_r[5].enable |=> rail_on[5])
    else $error("enable bit did not switch rail on");

endmodule

// *** testbench/ldo_host_model.sv ***
// Purpose: host model driving the register port
// Assumes: one-cycle strobes, inputs changed at falling edge
// Notes: gap adds idle cycles so the host can be slow
`timescale 1ns/1ps
module ldo_host_model #(parameter int GAP = 0) (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one whole byte per write, each rail written on its own
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    repeat (2 + GAP) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    // answer stands for one cycle only, take it now
    ok = reg_rvalid;
    d = reg_rdata;
    reg_rd = 1'b0;
    repeat (1 + GAP) @(negedge sys_clk);
  endtask
endmodule

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the regulator register bank
// Assumes: fixed read latency of one cycle, outputs two edges after write
// Notes: register enables are left off before the pin scenario
`timescale 1ns/1ps
module testbench;
  import ldo_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic startup_done = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [7:0] pg_comp = 8'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, wide_rail_range_select;
  logic [7:0] rail_on, rail_discharge;
  logic [5:0] wide_rail_voltage_code;
  ldo_code_t rail_code [LDO_RAILS];
  ldo_mv_t rail_target_mv [LDO_RAILS];
  int num_errors = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  ldo_host_model #(.GAP(1)) host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  ldo_ctl_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .startup_done(startup_done), .oscillator_rail_pin(pins[0]), .rx_rail_pin(pins[1]),
    .tx_rail_pin(pins[2]), .power_keep_pin(pins[3]), .pg_comp(pg_comp), .rail_on(rail_on),
    .rail_discharge(rail_discharge), .rail_code(rail_code), .rail_target_mv(rail_target_mv),
    .wide_rail_voltage_code(wide_rail_voltage_code), .wide_rail_range_select(wide_rail_range_select));
  // ==========================================================
  // compare helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk({11'h000, ok}, 12'h001);
    chk({4'h0, d}, {4'h0, exp});
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_rail6();
    pg_comp = 8'h20;
    host.wr(LDO6_CTL_OFS, 8'h7F);
    rd_chk(LDO6_CTL_OFS, 8'h7F);
    chk({rail_on[5], 6'h00, rail_code[5]}, {1'b1, 6'h00, 5'h1F});
    chk(rail_target_mv[5], 12'hE74);
    pg_comp = 8'h00;
    host.wr(LDO6_CTL_OFS, 8'hC0);
    rd_chk(LDO6_CTL_OFS, 8'h80);
    chk({rail_on[5], rail_discharge[5]}, 12'h001);
  endtask
  task automatic t_wide();
    rd_chk(LDO7_CTL_OFS, 8'h00);
    host.wr(LDO7_CTL_OFS, 8'hFF);
    rd_chk(LDO7_CTL_OFS, 8'hA0);
    chk({rail_on[6], rail_discharge[6], rail_code[6]}, 12'h040);
    host.wr(LDO7_CTL_OFS, 8'h80);
    chk({rail_on[6], rail_discharge[6]}, 12'h001);
  endtask
  task automatic t_wcode();
    host.wr(LDO_WIDE_CODE_OFS, 8'h3F);
    chk({wide_rail_range_select, wide_rail_voltage_code}, 12'h03F);
    host.wr(LDO_WIDE_CODE_OFS, 8'h71);
    chk({wide_rail_range_select, wide_rail_voltage_code}, 12'h071);
    // deliberately an unavailable code, must be refused whole
    host.wr(LDO_WIDE_CODE_OFS, 8'h72);
    chk({wide_rail_range_select, wide_rail_voltage_code}, 12'h071);
    rd_chk(LDO_WIDE_CODE_OFS, 8'h71);
  endtask
  task automatic t_table();
    int base [4] = '{1400, 2150, 2550, 3000};
    int step [4] = '{100, 50, 50, 100};
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 8; s += 7) begin
        host.wr(LDO5_CTL_OFS, 8'(b * 8 + s));
        chk(rail_target_mv[4], 12'(base[b] + step[b] * s));
        chk({7'h00, rail_code[4]}, 12'(b * 8 + s));
      end
    end
  endtask
  task automatic t_pins();
    logic [7:0] mask [4] = '{8'h08, 8'h10, 8'h20, 8'hC7};
    pins = 4'h8;
    repeat (3) @(negedge sys_clk);
    chk({4'h0, rail_on}, 12'h000);
    startup_done = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pins = 4'(1 << i);
      repeat (3) @(negedge sys_clk);
      chk({4'h0, rail_on}, {4'h0, mask[i]});
    end
    host.wr(LDO6_CTL_OFS, 8'h20);
    chk({4'h0, rail_on}, 12'h0E7);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    t_rail6();
    t_wide();
    t_wcode();
    t_table();
    t_pins();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
